// ==== pkg/usbdst_pkg.sv ====
// Purpose: Shared constants and types for the device state tracker.
// Assumes: A 40 MHz core clock and APB register access.
// Notes: Endpoint 0 is the control endpoint and belongs to no interface.
package usbdst_pkg;
  // Clock rate and bus inactivity time before suspend.
  localparam int CLK_HZ   = 40_000_000;
  localparam int IDLE_US  = 3000;
  localparam int IDLE_CYC = (CLK_HZ / 1_000_000) * IDLE_US;

  // Endpoint, interface and configuration layout.
  localparam int              NUM_EP  = 4;
  localparam int              NUM_IF  = 2;
  localparam int              ALT_W   = 4;
  localparam logic [7:0]      IF_CNT  = 8'h02;
  localparam logic [7:0]      ALT_CNT = 8'h02;
  localparam logic [7:0]      CFG_CNT = 8'h01;
  localparam logic [3:0]      EP_IF1  = 4'hC;
  localparam logic [3:0]      EP_CTRL = 4'h1;
  localparam logic [3:0]      EP_NONE = 4'h0;
  localparam logic [3:0]      EP_ALL  = 4'hF;
  localparam logic [6:0]      ADDR_DFLT = 7'h00;

  // Register byte offsets.
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_STAT = 12'h004;
  localparam logic [11:0] OFF_ALT  = 12'h008;
  localparam logic [11:0] OFF_TOG  = 12'h00C;

  // Field positions and reset values.
  localparam int          CTRL_RWU_CAP = 0;
  localparam int          CTRL_WAKE    = 1;
  localparam int          STAT_SUSP    = 2;
  localparam int          STAT_RWU     = 3;
  localparam int          STAT_ADDR    = 8;
  localparam int          STAT_CFG     = 16;
  localparam logic [31:0] CTRL_RST     = 32'h0000_0000;

  // Visible device states.
  typedef enum logic [1:0] {
    DS_POWERED = 2'b00,
    DS_DEFAULT = 2'b01,
    DS_ADDRESS = 2'b10,
    DS_CONFIG  = 2'b11
  } usbdst_dev_t;

  // Decoded standard request, one strobe per kind.
  typedef struct packed {
    logic       set_addr;
    logic       set_cfg;
    logic       set_alt;
    logic       get_alt;
    logic       rwu_set;
    logic       rwu_clr;
    logic [6:0] addr;
    logic [7:0] cfg;
    logic [7:0] intf;
    logic [7:0] alt;
  } usbdst_req_t;

  // Answer to a request.
  typedef struct packed {
    logic       done;
    logic       stall;
    logic [7:0] alt;
  } usbdst_ans_t;

  // APB request side.
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } usbdst_apb_t;

  // Endpoints owned by interface 0 or 1.
  function automatic logic [3:0] usbdst_if_eps(input logic sel);
    return sel ? EP_IF1 : (EP_ALL & ~EP_IF1 & ~EP_CTRL);
  endfunction : usbdst_if_eps
endpackage : usbdst_pkg

// ==== rtl/usbdst_idle_tmr.sv ====
// Purpose: Counts cycles without bus traffic and flags expiry.
// Assumes: Activity is a synchronous level, high in any cycle with traffic.
// Notes: Expire is a one-cycle pulse; the count restarts after it.
module usbdst_idle_tmr #(
  parameter int IDLE_CYCLES = usbdst_pkg::IDLE_CYC
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic srst,
  // Control
  input  wire logic run,
  input  wire logic activity,
  // Result
  output logic      expire
);
  typedef struct packed {
    logic [31:0] cnt;
  } usbdst_tmr_t;

  usbdst_tmr_t s_q;
  usbdst_tmr_t s_d;

  // Count while running; any traffic restarts the wait.
  always_comb begin
    s_d    = s_q;
    expire = run && !activity && (s_q.cnt == 32'(IDLE_CYCLES - 1));
    if (!run || activity || expire) begin
      s_d.cnt = 32'h0000_0000;
    end else begin
      s_d.cnt = s_q.cnt + 32'h0000_0001;
    end
  end

  // State register.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : usbdst_idle_tmr

// ==== rtl/usbdst_apb.sv ====
// Purpose: APB slave with zero wait states for the tracker registers.
// Assumes: A master that follows the setup and access phases.
// Notes: Read data is captured in the setup cycle, so it is one cycle old.
module usbdst_apb (
  // Clock and reset
  input  wire logic               core_clk,
  input  wire logic               srst,
  // APB
  input  wire usbdst_pkg::usbdst_apb_t apb,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Register contents
  input  wire logic [31:0]        ctrl_w,
  input  wire logic [31:0]        stat_w,
  input  wire logic [31:0]        alt_w,
  input  wire logic [31:0]        tog_w,
  // Control write
  output logic                    ctrl_we,
  output logic [31:0]             ctrl_wdata
);
  typedef struct packed {
    logic [31:0] rdata;
    logic        err;
  } usbdst_apbst_t;

  usbdst_apbst_t s_q;
  usbdst_apbst_t s_d;

  // Decode in the setup cycle; unmapped offsets answer with an error.
  always_comb begin
    s_d = s_q;
    if (apb.psel && !apb.penable) begin
      s_d.err = 1'b0;
      case (apb.paddr)
        usbdst_pkg::OFF_CTRL: s_d.rdata = ctrl_w;
        usbdst_pkg::OFF_STAT: s_d.rdata = stat_w;
        usbdst_pkg::OFF_ALT:  s_d.rdata = alt_w;
        usbdst_pkg::OFF_TOG:  s_d.rdata = tog_w;
        default: begin
          s_d.rdata = 32'h0000_0000;
          s_d.err   = 1'b1;
        end
      endcase
    end
  end

  // Writes take effect at the single access edge.
  assign pready     = 1'b1;
  assign prdata     = s_q.rdata;
  assign pslverr    = s_q.err && apb.psel && apb.penable;
  assign ctrl_we    = apb.psel && apb.penable && apb.pwrite && !s_q.err
                      && (apb.paddr == usbdst_pkg::OFF_CTRL);
  assign ctrl_wdata = apb.pwdata;

  // State register.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : usbdst_apb

// ==== rtl/usbdst_top.sv ====
// Purpose: Device state tracker: address, configuration, suspend, wakeup.
// Assumes: Requests arrive decoded, one strobe per cycle, from the control
//   pipe logic; bus_reset is high while reset signaling lasts.
// Notes: Endpoint 0 is always usable once reset has been seen.
// Behaviour
// - Default address after power-up and reset.
// - Control pipe answers at default or assigned address.
// - Configured only after valid nonzero configuration.
// - Configuration or alternate change resets endpoints, toggles.
// - Suspend after bus inactivity period.
// - Inactivity period is 3 ms.
// - Suspend keeps address and configuration.
// - Suspend possible in any powered state; the code suspends only after the first bus reset.
// - Disabled upstream port forces suspend.
// - Bus activity ends suspend.
// - Host enables and disables remote wakeup.
// - Bus reset disables remote wakeup.
// - After reset: Default state, everything reset.
// - Ignore bus until first bus reset.
// - Address assignment moves Default to Address.
// - Configured endpoints take their described characteristics.
// - Reset device unconfigured, not suspended, default address.
// - Alternate setting readable and writable per interface.
// - Interfaces, alternates from zero; alternate zero first.
//
// Implementation choices: the APB register port and the address map.
module usbdst_top #(
  parameter int IDLE_CYCLES = usbdst_pkg::IDLE_CYC
) (
  // Clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    srst,
  // Bus condition
  input  wire logic                    bus_reset,
  input  wire logic                    bus_activity,
  input  wire logic                    port_enabled,
  // Token address check
  input  wire logic                    tok_valid,
  input  wire logic [6:0]              tok_addr,
  output logic                         tok_hit,
  // Standard requests
  input  wire usbdst_pkg::usbdst_req_t req,
  output usbdst_pkg::usbdst_ans_t      ans,
  // Endpoints
  input  wire logic [3:0]              ep_ack,
  output logic [3:0]                   ep_toggle,
  output logic [3:0]                   ep_enable,
  output logic [3:0]                   ep_defaults,
  // Device condition
  output usbdst_pkg::usbdst_dev_t      dev_state,
  output logic [6:0]                   dev_addr,
  output logic [7:0]                   cfg_value,
  output logic                         suspended,
  output logic                         rwu_enable,
  output logic                         wake_pulse,
  // APB
  input  wire usbdst_pkg::usbdst_apb_t apb,
  output logic [31:0]                  prdata,
  output logic                         pready,
  output logic                         pslverr
);
  typedef struct packed {
    usbdst_pkg::usbdst_dev_t       state;
    logic                          susp;
    logic                          rwu;
    logic                          rwu_cap;
    logic [6:0]                    addr;
    logic [7:0]                    cfg;
    logic [1:0][3:0]               alt;
    logic [3:0]                    tog;
    logic [3:0]                    en;
    logic [3:0]                    dflt;
    logic                          wake;
    usbdst_pkg::usbdst_ans_t       ans;
  } usbdst_st_t;

  usbdst_st_t  s_q;
  usbdst_st_t  s_d;
  logic        live;
  logic        idle_exp;
  logic        tmr_run;
  logic        ctrl_we;
  logic [31:0] ctrl_wdata;
  logic [31:0] ctrl_w;
  logic [31:0] stat_w;
  logic [31:0] alt_w;
  logic [31:0] tog_w;
  logic        if_ok;
  logic        alt_ok;
  logic        cfg_ok;
  logic        if_sel;

  // Requests count only once reset has been seen and the bus is awake.
  assign live    = !bus_reset && (s_q.state != usbdst_pkg::DS_POWERED) && !s_q.susp;
  assign tmr_run = live;
  assign if_ok   = req.intf < usbdst_pkg::IF_CNT;
  assign alt_ok  = req.alt < usbdst_pkg::ALT_CNT;
  assign cfg_ok  = req.cfg <= usbdst_pkg::CFG_CNT;
  assign if_sel  = req.intf[0];

  // Inactivity timer that drives the automatic suspend.
  usbdst_idle_tmr #(
    .IDLE_CYCLES (IDLE_CYCLES)
  ) u_idle (
    .core_clk (core_clk),
    .srst     (srst),
    .run      (tmr_run),
    .activity (bus_activity),
    .expire   (idle_exp)
  );

  // Register words as software sees them.
  assign ctrl_w = 32'(s_q.rwu_cap) << usbdst_pkg::CTRL_RWU_CAP;
  assign stat_w = 32'(s_q.state)
                  | (32'(s_q.susp) << usbdst_pkg::STAT_SUSP)
                  | (32'(s_q.rwu) << usbdst_pkg::STAT_RWU)
                  | (32'(s_q.addr) << usbdst_pkg::STAT_ADDR)
                  | (32'(s_q.cfg) << usbdst_pkg::STAT_CFG);
  assign alt_w  = {24'h00_0000, s_q.alt};
  assign tog_w  = {28'h000_0000, s_q.tog};

  // Register slave.
  usbdst_apb u_apb (
    .core_clk   (core_clk),
    .srst       (srst),
    .apb        (apb),
    .prdata     (prdata),
    .pready     (pready),
    .pslverr    (pslverr),
    .ctrl_w     (ctrl_w),
    .stat_w     (stat_w),
    .alt_w      (alt_w),
    .tog_w      (tog_w),
    .ctrl_we    (ctrl_we),
    .ctrl_wdata (ctrl_wdata)
  );

  // Next state: bus reset first, then suspend, then requests.
  always_comb begin
    s_d           = s_q;
    s_d.ans.done  = 1'b0;
    s_d.ans.stall = 1'b0;
    s_d.dflt      = usbdst_pkg::EP_NONE;
    s_d.wake      = 1'b0;
    if (ctrl_we) begin
      s_d.rwu_cap = ctrl_wdata[usbdst_pkg::CTRL_RWU_CAP];
      // Wakeup only goes out while suspended and allowed by the host.
      s_d.wake    = ctrl_wdata[usbdst_pkg::CTRL_WAKE] && s_q.susp && s_q.rwu;
    end
    if (bus_reset) begin
      s_d.state = usbdst_pkg::DS_DEFAULT;
      s_d.addr  = usbdst_pkg::ADDR_DFLT;
      s_d.susp  = 1'b0;
      s_d.rwu   = 1'b0;
      s_d.cfg   = 8'h00;
      s_d.alt   = '0;
      s_d.tog   = usbdst_pkg::EP_NONE;
      s_d.dflt  = usbdst_pkg::EP_ALL;
      s_d.wake  = 1'b0;
    end else if (s_q.state == usbdst_pkg::DS_POWERED) begin
      // Nothing on the bus counts before the first reset.
      s_d.state = usbdst_pkg::DS_POWERED;
    end else if (s_q.susp) begin
      // Address and configuration are simply left alone here.
      if (bus_activity && port_enabled) begin
        s_d.susp = 1'b0;
      end
    end else if (idle_exp || !port_enabled) begin
      s_d.susp = 1'b1;
    end else begin
      // Data toggles flip on each acknowledged packet.
      s_d.tog = s_q.tog ^ (ep_ack & s_q.en);
      if (req.set_addr) begin
        s_d.ans.done = 1'b1;
        if (s_q.state == usbdst_pkg::DS_CONFIG) begin
          s_d.ans.stall = 1'b1;
        end else if (req.addr != usbdst_pkg::ADDR_DFLT) begin
          s_d.addr  = req.addr;
          s_d.state = usbdst_pkg::DS_ADDRESS;
        end else begin
          s_d.addr  = usbdst_pkg::ADDR_DFLT;
          s_d.state = usbdst_pkg::DS_DEFAULT;
        end
      end else if (req.set_cfg) begin
        s_d.ans.done = 1'b1;
        if (s_q.state == usbdst_pkg::DS_DEFAULT || !cfg_ok) begin
          s_d.ans.stall = 1'b1;
        end else if (req.cfg != 8'h00) begin
          s_d.state = usbdst_pkg::DS_CONFIG;
          s_d.cfg   = req.cfg;
          s_d.alt   = '0;
          s_d.tog   = usbdst_pkg::EP_NONE;
          s_d.dflt  = usbdst_pkg::EP_ALL & ~usbdst_pkg::EP_CTRL;
        end else begin
          s_d.state = usbdst_pkg::DS_ADDRESS;
          s_d.cfg   = 8'h00;
          s_d.dflt  = usbdst_pkg::EP_ALL & ~usbdst_pkg::EP_CTRL;
        end
      end else if (req.set_alt) begin
        s_d.ans.done = 1'b1;
        if (s_q.state != usbdst_pkg::DS_CONFIG || !if_ok || !alt_ok) begin
          s_d.ans.stall = 1'b1;
        end else begin
          s_d.alt[if_sel] = req.alt[3:0];
          s_d.tog  = s_d.tog & ~usbdst_pkg::usbdst_if_eps(if_sel);
          s_d.dflt = usbdst_pkg::usbdst_if_eps(if_sel);
        end
      end else if (req.get_alt) begin
        s_d.ans.done = 1'b1;
        if (s_q.state != usbdst_pkg::DS_CONFIG || !if_ok) begin
          s_d.ans.stall = 1'b1;
        end else begin
          s_d.ans.alt = {4'h0, s_q.alt[if_sel]};
        end
      end else if (req.rwu_set) begin
        s_d.ans.done  = 1'b1;
        s_d.ans.stall = !s_q.rwu_cap;
        s_d.rwu       = s_q.rwu_cap;
      end else if (req.rwu_clr) begin
        s_d.ans.done = 1'b1;
        s_d.rwu      = 1'b0;
      end
    end
    // Only the control endpoint is usable until configured.
    case (s_d.state)
      usbdst_pkg::DS_POWERED: s_d.en = usbdst_pkg::EP_NONE;
      usbdst_pkg::DS_CONFIG:  s_d.en = usbdst_pkg::EP_ALL;
      default:                s_d.en = usbdst_pkg::EP_CTRL;
    endcase
  end

  // Power-up leaves the device waiting for its first bus reset.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_q       <= '0;
      s_q.state <= usbdst_pkg::DS_POWERED;
    end else begin
      s_q <= s_d;
    end
  end

  // Match is combinational so the packet logic can answer in time.
  assign tok_hit     = tok_valid && live && (tok_addr == s_q.addr);
  assign ans         = s_q.ans;
  assign ep_toggle   = s_q.tog;
  assign ep_enable   = s_q.en;
  assign ep_defaults = s_q.dflt;
  assign dev_state   = s_q.state;
  assign dev_addr    = s_q.addr;
  assign cfg_value   = s_q.cfg;
  assign suspended   = s_q.susp;
  assign rwu_enable  = s_q.rwu;
  assign wake_pulse  = s_q.wake;

  // Cycles since the last traffic, kept only for the checks below.
  int idle_h;
  always_ff @(posedge core_clk) begin
    if (srst || bus_reset || bus_activity || s_q.state == usbdst_pkg::DS_POWERED) begin
      idle_h <= 0;
    end else begin
      idle_h <= idle_h + 1;
    end
  end

  // A request is taken only on an enabled port with no idle expiry due.
  logic take_h;
  assign take_h = live && port_enabled && !idle_exp;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  a_powered_quiet: assert property (
    (s_q.state == usbdst_pkg::DS_POWERED) |-> !tok_hit && ep_enable == 4'h0
  ) else $error("device answered before its first bus reset");

  a_default_hit: assert property (
    tok_valid && live && s_q.state == usbdst_pkg::DS_DEFAULT && tok_addr == 7'h00
    |-> tok_hit
  ) else $error("default address not answered");

  a_foreign_miss: assert property (
    tok_valid && tok_addr != dev_addr |-> !tok_hit
  ) else $error("token for another address matched");

  a_cfg_enter: assert property (
    $rose(dev_state == usbdst_pkg::DS_CONFIG) |-> $past(req.set_cfg) && cfg_value != 8'h00
  ) else $error("configured without a nonzero configuration request");

  a_cfg_defaults: assert property (
    take_h && req.set_cfg && !req.set_addr && req.cfg == 8'h01
    && s_q.state != usbdst_pkg::DS_DEFAULT
    |=> ep_toggle == 4'h0 && ep_defaults == 4'hE && s_q.alt == '0 ##1 ep_defaults == 4'h0
  ) else $error("configuration did not restore endpoint defaults");

  a_idle_suspend: assert property (
    idle_h >= IDLE_CYCLES |-> suspended
  ) else $error("no suspend after the inactivity period");

  a_idle_exact: assert property (
    $rose(suspended) |-> idle_h == IDLE_CYCLES || $past(!port_enabled)
  ) else $error("suspend came before the inactivity period");

  a_susp_keep: assert property (
    suspended && !bus_reset |=> $stable(dev_addr) && $stable(cfg_value) && $stable(dev_state)
  ) else $error("state changed while suspended");

  a_port_off: assert property (
    !port_enabled && !bus_reset && dev_state != usbdst_pkg::DS_POWERED |=> suspended
  ) else $error("disabled port did not suspend the device");

  a_resume: assert property (
    suspended && bus_activity && port_enabled && !bus_reset |=> !suspended
  ) else $error("bus activity did not end suspend");

  a_reset_clear: assert property (
    bus_reset |=> !rwu_enable && dev_state == usbdst_pkg::DS_DEFAULT && !suspended
    && dev_addr == 7'h00 && cfg_value == 8'h00
  ) else $error("bus reset left state behind");

  a_rwu_refuse: assert property (
    take_h && req.rwu_set && !s_q.rwu_cap && !req.set_addr && !req.set_cfg && !req.set_alt
    && !req.get_alt |=> ans.stall && !rwu_enable
  ) else $error("wakeup enabled without the capability");

  a_addr_move: assert property (
    take_h && req.set_addr && req.addr != 7'h00 && s_q.state == usbdst_pkg::DS_DEFAULT
    |=> dev_state == usbdst_pkg::DS_ADDRESS && dev_addr == $past(req.addr)
  ) else $error("address assignment did not move the state");

  a_cfg_zero: assert property (
    take_h && req.set_cfg && req.cfg == 8'h00 && !req.set_addr
    && s_q.state == usbdst_pkg::DS_CONFIG |=> dev_state == usbdst_pkg::DS_ADDRESS
    && ep_enable == 4'h1
  ) else $error("configuration zero did not deconfigure");

  c_enumerate: cover property (
    dev_state == usbdst_pkg::DS_ADDRESS ##[1:50] dev_state == usbdst_pkg::DS_CONFIG);
  c_idle_susp: cover property ($rose(suspended) && port_enabled);
  c_resume: cover property ($fell(suspended));
  c_wake: cover property (wake_pulse);
endmodule : usbdst_top

// ==== sim/usbdst_host.sv ====
// Purpose: Host side model: port enable, bus reset, requests, tokens and acks.
// Assumes: Tasks are called from the bench and change lines by nonblocking assignment.
// Notes: The attach wait is a scaled stand-in for the long settle time before reset.
module usbdst_host #(
  parameter int ATTACH_WAIT = 10
) (
  // Clock
  input  wire logic            core_clk,
  // Bus condition toward the device
  output logic                 bus_reset,
  output logic                 bus_activity,
  output logic                 port_enabled,
  // Tokens, requests and acks
  output logic                 tok_valid,
  output logic [6:0]           tok_addr,
  output usbdst_pkg::usbdst_req_t req,
  output logic [3:0]           ep_ack
);
  timeunit 1ns;
  timeprecision 100ps;

  // Lines start with bus_activity high, no request or token, and the port still disabled, as on attach.
  initial begin
    bus_reset    = 1'b0;
    bus_activity = 1'b1;
    port_enabled = 1'b0;
    tok_valid    = 1'b0;
    tok_addr     = 7'h7F;
    req          = '0;
    ep_ack       = 4'h0;
  end

  // Settle first, then enable the port together with reset signaling.
  task automatic attach_reset();
    repeat (ATTACH_WAIT) @(posedge core_clk);
    port_enabled <= 1'b1;
    bus_reset    <= 1'b1;
    repeat (3) @(posedge core_clk);
    bus_reset <= 1'b0;
    @(posedge core_clk);
  endtask : attach_reset

  // One request strobe: 0 address, 1 config, 2 set alt, 3 get alt, 4/5 wakeup on/off.
  task automatic issue(input int k, input logic [7:0] v, input logic [7:0] i);
    usbdst_pkg::usbdst_req_t r;
    r = '0;
    r.addr = v[6:0];
    r.cfg  = v;
    r.alt  = v;
    r.intf = i;
    case (k)
      0: r.set_addr = 1'b1;
      1: r.set_cfg  = 1'b1;
      2: r.set_alt  = 1'b1;
      3: r.get_alt  = 1'b1;
      4: r.rwu_set  = 1'b1;
      default: r.rwu_clr = 1'b1;
    endcase
    @(posedge core_clk);
    req <= r;
    @(posedge core_clk);
    req <= '0;
  endtask : issue

  // Descriptor reads address the control pipe; only the token address matters here.
  task automatic tok(input logic [6:0] a);
    @(posedge core_clk);
    tok_valid <= 1'b1;
    tok_addr  <= a;
  endtask : tok

  // One handshake per endpoint in the mask.
  task automatic ack(input logic [3:0] m);
    @(posedge core_clk);
    ep_ack <= m;
    @(posedge core_clk);
    ep_ack <= 4'h0;
  endtask : ack

  // Traffic level and port enable change together at one edge.
  task automatic line(input logic act, input logic en);
    @(posedge core_clk);
    bus_activity <= act;
    port_enabled <= en;
  endtask : line
endmodule : usbdst_host

// ==== sim/usb_device_state_tracker_test.sv ====
// Purpose: Self-checking bench for the device state tracker.
// Assumes: Short idle count; request answers are registered at the taking edge.
// Notes: Only mismatches and the verdict are printed.
module usb_device_state_tracker_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int IDLE = 20;
  logic core_clk, srst, bus_reset, bus_activity, port_enabled, tok_valid, tok_hit;
  logic suspended, rwu_enable, wake_pulse, pready, pslverr, err;
  logic [6:0] tok_addr, dev_addr;
  logic [3:0] ep_ack, ep_toggle, ep_enable, ep_defaults;
  logic [7:0] cfg_value;
  logic [31:0] prdata, rd;
  usbdst_pkg::usbdst_req_t req;
  usbdst_pkg::usbdst_ans_t ans;
  usbdst_pkg::usbdst_dev_t dev_state;
  usbdst_pkg::usbdst_apb_t apb;
  int failures, n_tests, cyc;

  usbdst_host host (.core_clk, .bus_reset, .bus_activity, .port_enabled, .tok_valid,
    .tok_addr, .req, .ep_ack);
  usbdst_top #(.IDLE_CYCLES(IDLE)) dut (.core_clk, .srst, .bus_reset, .bus_activity,
    .port_enabled, .tok_valid, .tok_addr, .tok_hit, .req, .ans, .ep_ack, .ep_toggle,
    .ep_enable, .ep_defaults, .dev_state, .dev_addr, .cfg_value, .suspended, .rwu_enable,
    .wake_pulse, .apb, .prdata, .pready, .pslverr);

  // Clock at 40 MHz.
  always #12.5 core_clk = ~core_clk;

  // A hang counts as a mismatch rather than running on forever.
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      complete_run();
    end
  end

  // Compare and count.
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // One APB transfer; the request holds until pready is seen at an access edge.
  task automatic apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge core_clk);
    apb.penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    apb <= '0;
  endtask : apb_xfer

  // Verdict and end of run.
  task automatic complete_run();
    if (failures == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run

  // Requests and tokens are ignored until a bus reset has been seen.
  task automatic t_powered();
    host.issue(1, 8'h01, 8'h00);
    #1 chk("done", 0, ans.done);
    host.tok(7'h00);
    #1 chk("hit", 0, tok_hit);
    chk("state", usbdst_pkg::DS_POWERED, dev_state);
  endtask : t_powered

  // Reset leaves a fresh device at the default address.
  task automatic t_reset();
    host.attach_reset();
    #1 chk("state", usbdst_pkg::DS_DEFAULT, dev_state);
    chk("addr", usbdst_pkg::ADDR_DFLT, dev_addr);
    chk("cfg", 0, cfg_value);
    chk("susp", 0, suspended);
    chk("rwu", 0, rwu_enable);
    host.tok(7'h00);
    #1 chk("hit", 1, tok_hit);
  endtask : t_reset

  // Address assignment moves the control pipe to the new address.
  task automatic t_address();
    host.issue(0, 8'h05, 8'h00);
    #1 chk("done", 1, ans.done);
    chk("state", usbdst_pkg::DS_ADDRESS, dev_state);
    host.tok(7'h05);
    #1 chk("hit", 1, tok_hit);
    host.tok(7'h00);
    #1 chk("hit", 0, tok_hit);
  endtask : t_address

  // An out of range value stalls; a valid one configures with fresh endpoints.
  task automatic t_config();
    host.issue(1, 8'h02, 8'h00);
    #1 chk("stall", 1, ans.stall);
    chk("state", usbdst_pkg::DS_ADDRESS, dev_state);
    host.issue(1, 8'h01, 8'h00);
    #1 chk("state", usbdst_pkg::DS_CONFIG, dev_state);
    chk("cfg", 1, cfg_value);
    chk("en", 4'hF, ep_enable);
    chk("dflt", 4'hE, ep_defaults);
    chk("tog", 0, ep_toggle);
    for (int i = 0; i < 2; i++) begin
      host.issue(3, 8'h00, 8'(i));
      #1 chk("alt", 0, ans.alt);
    end
  endtask : t_config

  // An alternate change resets only the endpoints of that interface.
  task automatic t_alt();
    host.ack(4'h6);
    #1 chk("tog", 4'h6, ep_toggle);
    host.issue(2, 8'h01, 8'h00);
    #1 chk("dflt", 4'h2, ep_defaults);
    chk("tog", 4'h4, ep_toggle);
    host.issue(3, 8'h00, 8'h00);
    #1 chk("alt", 1, ans.alt);
    host.issue(2, 8'h02, 8'h01);
    #1 chk("stall", 1, ans.stall);
  endtask : t_alt

  // Wakeup capability and enable under host control; unmapped offset refused.
  task automatic t_rwu();
    host.issue(4, 8'h00, 8'h00);
    #1 chk("stall", 1, ans.stall);
    chk("rwu", 0, rwu_enable);
    host.issue(0, 8'h07, 8'h00);
    #1 chk("stall", 1, ans.stall);
    chk("addr", 7'h05, dev_addr);
    apb_xfer(1'b1, usbdst_pkg::OFF_CTRL, 32'h0000_0001);
    host.issue(4, 8'h00, 8'h00);
    #1 chk("rwu", 1, rwu_enable);
    host.issue(5, 8'h00, 8'h00);
    #1 chk("rwu", 0, rwu_enable);
    host.issue(4, 8'h00, 8'h00);
    apb_xfer(1'b0, usbdst_pkg::OFF_STAT, 32'h0000_0000);
    chk("stat", 32'h0001_050B, rd);
    apb_xfer(1'b0, 12'h010, 32'h0000_0000);
    chk("err", 1, err);
  endtask : t_rwu

  // Idle and a disabled port both suspend; activity on an enabled port resumes.
  task automatic t_suspend();
    host.line(1'b0, 1'b1);
    repeat (IDLE - 2) @(posedge core_clk);
    #1 chk("susp", 0, suspended);
    repeat (4) @(posedge core_clk);
    #1 chk("susp", 1, suspended);
    chk("addr", 7'h05, dev_addr);
    chk("cfg", 1, cfg_value);
    apb_xfer(1'b1, usbdst_pkg::OFF_CTRL, 32'h0000_0003);
    #1 chk("wake", 1, wake_pulse);
    host.line(1'b1, 1'b1);
    @(posedge core_clk);
    #1 chk("susp", 0, suspended);
    host.line(1'b1, 1'b0);
    @(posedge core_clk);
    #1 chk("susp", 1, suspended);
    host.line(1'b1, 1'b1);
    @(posedge core_clk);
    #1 chk("susp", 0, suspended);
  endtask : t_suspend

  // Configuration zero drops back to addressed; a second reset clears wakeup.
  task automatic t_unconfig();
    host.issue(1, 8'h00, 8'h00);
    #1 chk("state", usbdst_pkg::DS_ADDRESS, dev_state);
    chk("en", 4'h1, ep_enable);
    t_reset();
  endtask : t_unconfig

  // Main sequence.
  initial begin
    core_clk = 1'b0;
    srst     = 1'b1;
    apb      = '0;
    failures = 0;
    n_tests  = 0;
    cyc      = 0;
    repeat (6) @(posedge core_clk);
    srst <= 1'b0;
    t_powered();
    t_reset();
    t_address();
    t_config();
    t_alt();
    t_rwu();
    t_suspend();
    t_unconfig();
    complete_run();
  end
endmodule : usb_device_state_tracker_test
